// ==== verilog/phyifm_top.sv ====
// Module: PHY interrupt source flags and enable mask with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none

module phyifm_top (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // PHY event indications
  input  wire phyifm_pkg::phyifm_evt_t evt,
  // Combined interrupt request
  output logic                      irq
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] reg_addr);
    addr_hit = ((a & phyifm_pkg::ADDR_WORD_MASK) == reg_addr) && ((a & ~phyifm_pkg::ADDR_WORD_MASK) == 32'h00000000);
  endfunction

  logic        addr_phase;
  logic        rd_flags;
  logic        rd_mask;
  logic        wr_flags_req;
  logic        wr_mask_req;

  always_comb begin
    addr_phase   = hsel && hready && (htrans == phyifm_pkg::HTRANS_NONSEQ);
    rd_flags     = addr_phase && !hwrite && addr_hit(haddr, phyifm_pkg::ADDR_SOURCE_FLAGS);
    rd_mask      = addr_phase && !hwrite && addr_hit(haddr, phyifm_pkg::ADDR_ENABLE_MASK);
    wr_flags_req = addr_phase && hwrite && addr_hit(haddr, phyifm_pkg::ADDR_SOURCE_FLAGS);
    wr_mask_req  = addr_phase && hwrite && addr_hit(haddr, phyifm_pkg::ADDR_ENABLE_MASK);
  end

  // ----------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------
  logic        wr_flags_pend;
  logic        wr_mask_pend;
  logic [31:0] next_hrdata;
  logic        next_wr_flags_pend;
  logic        next_wr_mask_pend;

  logic [15:0] flags;
  logic [15:0] mask;
  logic        link_prev;
  logic        energy_prev;

  // Read data is loaded at the address-phase edge, so reads are zero-wait
  always_comb begin
    next_wr_flags_pend = wr_flags_req;
    next_wr_mask_pend  = wr_mask_req;
    next_hrdata        = 32'h00000000;
    if (rd_flags) begin
      next_hrdata = {16'h0000, flags & phyifm_pkg::VALID_BITS};
    end else if (rd_mask) begin
      next_hrdata = {16'h0000, mask & phyifm_pkg::VALID_BITS};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hrdata        <= 32'h00000000;
      hreadyout     <= 1'h1;
      hresp         <= phyifm_pkg::HRESP_OKAY;
      wr_flags_pend <= 1'h0;
      wr_mask_pend  <= 1'h0;
    end else begin
      hrdata        <= next_hrdata;
      hreadyout     <= 1'h1;
      hresp         <= phyifm_pkg::HRESP_OKAY;
      wr_flags_pend <= next_wr_flags_pend;
      wr_mask_pend  <= next_wr_mask_pend;
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic [15:0] raw_set;

  always_comb begin
    raw_set = 16'h0000;
    raw_set[phyifm_pkg::BIT_LINK_UP]               = evt.link_status && !link_prev;
    raw_set[phyifm_pkg::BIT_WAKE_EVENT]            = evt.wake_on_network;
    raw_set[phyifm_pkg::BIT_ENERGY_DETECT]         = evt.energy_present_indication && !energy_prev;
    raw_set[phyifm_pkg::BIT_AUTONEG_DONE]          = evt.autoneg_done;
    raw_set[phyifm_pkg::BIT_REMOTE_FAULT]          = evt.remote_fault;
    raw_set[phyifm_pkg::BIT_LINK_DOWN]             = !evt.link_status && link_prev;
    raw_set[phyifm_pkg::BIT_PARTNER_ACK]           = evt.partner_ack;
    raw_set[phyifm_pkg::BIT_PARALLEL_DETECT_FAULT] = evt.parallel_detect_fault;
    raw_set[phyifm_pkg::BIT_PAGE_RECEIVED]         = evt.page_received;
  end

  // ----------------------------------------------------------------
  // Flags, mask and interrupt
  // ----------------------------------------------------------------
  logic [15:0] flag_clear;
  logic [15:0] flag_set;
  logic [15:0] next_flags;
  logic [15:0] next_mask;
  logic        next_irq;

  always_comb begin
    flag_clear = 16'h0000;
    if (rd_flags) begin
      flag_clear = 16'hffff;
    end else if (wr_flags_pend) begin
      flag_clear = hwdata[15:0];
    end
    // Masked events are dropped, not held back for a later enable
    flag_set   = raw_set & mask & phyifm_pkg::VALID_BITS;
    // Set wins over a clear in the same cycle so no event is lost
    next_flags = ((flags & ~flag_clear) | flag_set) & phyifm_pkg::VALID_BITS;
    next_mask  = mask;
    if (wr_mask_pend) begin
      next_mask = hwdata[15:0] & phyifm_pkg::VALID_BITS;
    end
    // Mask written to zero also hides an already latched flag
    next_irq   = |(next_flags & next_mask);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags       <= phyifm_pkg::RESET_FLAGS;
      mask        <= phyifm_pkg::RESET_MASK;
      link_prev   <= 1'h0;
      energy_prev <= 1'h0;
      irq         <= 1'h0;
    end else begin
      flags       <= next_flags;
      mask        <= next_mask;
      link_prev   <= evt.link_status;
      energy_prev <= evt.energy_present_indication;
      irq         <= next_irq;
    end
  end

endmodule // phyifm_top

`default_nettype wire

// ==== common/phyifm_pkg.sv ====
// Package: register map, field layout and event carrier of the PHY interrupt flags block
package phyifm_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_SOURCE_FLAGS = 8'h1d;
  localparam logic [7:0]  IDX_ENABLE_MASK  = 8'h1e;
  localparam logic [31:0] ADDR_SOURCE_FLAGS = {22'h0, IDX_SOURCE_FLAGS, 2'h0};
  localparam logic [31:0] ADDR_ENABLE_MASK  = {22'h0, IDX_ENABLE_MASK, 2'h0};
  localparam logic [31:0] ADDR_WORD_MASK    = 32'h000003fc;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_PAGE_RECEIVED         = 1;
  localparam int BIT_PARALLEL_DETECT_FAULT = 2;
  localparam int BIT_PARTNER_ACK           = 3;
  localparam int BIT_LINK_DOWN             = 4;
  localparam int BIT_REMOTE_FAULT          = 5;
  localparam int BIT_AUTONEG_DONE          = 6;
  localparam int BIT_ENERGY_DETECT         = 7;
  localparam int BIT_WAKE_EVENT            = 8;
  localparam int BIT_LINK_UP               = 9;

  // Implemented bits 9..1; all others reserved
  localparam logic [15:0] VALID_BITS = 16'h03fe;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_FLAGS = 16'h0000;
  localparam logic [15:0] RESET_MASK  = 16'h0000;

  // ----------------------------------------------------------------
  // AHB encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Event indications from the PHY core, one cycle or level
  typedef struct packed {
    logic link_status;               // Level: link up when high
    logic energy_present_indication; // Level: energy detected
    logic wake_on_network;           // High while a wake event is seen
    logic autoneg_done;              // High when auto-negotiation finishes
    logic remote_fault;              // High while remote fault seen
    logic partner_ack;               // High when partner acknowledge seen
    logic parallel_detect_fault;     // High on parallel detection fault
    logic page_received;             // High when a page arrived
  } phyifm_evt_t;

endpackage : phyifm_pkg

// ==== verif/phyifm_props.sv ====
// Checker: flag, mask, read and interrupt properties
`timescale 1ns/10ps
`default_nettype none
module phyifm_props (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    reset,
  // Bus
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [31:0]             hwdata,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  // Events and interrupt
  input wire phyifm_pkg::phyifm_evt_t evt,
  input wire logic                    irq
);
  logic        lp, ep, wm;
  logic [15:0] msk;
  wire logic rd = hsel && hready && htrans == phyifm_pkg::HTRANS_NONSEQ && !hwrite;
  wire logic rdf = rd && haddr == phyifm_pkg::ADDR_SOURCE_FLAGS;
  wire logic rdm = rd && haddr == phyifm_pkg::ADDR_ENABLE_MASK;
  wire logic [15:0] hit = msk & {6'h00, evt.link_status && !lp, evt.wake_on_network,
    evt.energy_present_indication && !ep, evt.autoneg_done, evt.remote_fault, !evt.link_status && lp,
    evt.partner_ack, evt.parallel_detect_fault, evt.page_received, 1'b0};
  // Mask shadow lands in the write data phase, as in the slave
  always_ff @(posedge core_clk) begin
    lp <= !reset && evt.link_status;
    ep <= !reset && evt.energy_present_indication;
    wm <= !reset && hsel && hready && htrans == phyifm_pkg::HTRANS_NONSEQ && hwrite
      && haddr == phyifm_pkg::ADDR_ENABLE_MASK;
    msk <= reset ? 16'h0000 : wm ? hwdata[15:0] & phyifm_pkg::VALID_BITS : msk;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_hit_held;
    (|hit) ##1 $stable(msk);
  endsequence
  // Two reads three cycles apart with no enabled event between them
  sequence s_quiet_read;
    (rdf && hit == 16'h0) ##1 (hit == 16'h0) [*2] ##1 rdf;
  endsequence
  a_rdata_reserved: assert property (hrdata[31:10] == 22'h0 && !hrdata[0]) else $error("reserved bit");
  a_event_irq: assert property (s_hit_held |-> irq) else $error("no irq");
  a_masked_quiet: assert property (msk == 16'h0 ##1 msk == 16'h0 |-> !irq) else $error("masked irq");
  a_read_clears: assert property (s_quiet_read |=> hrdata == 32'h0) else $error("no clear");
  a_irq_cleared: assert property (rdf && hit == 16'h0 |=> !irq) else $error("irq stuck");
  a_mask_readback: assert property (rdm |=> hrdata[15:0] == $past(msk)) else $error("mask value");
  a_flag_latches: assert property ((|hit) ##1 rdf |=> (hrdata[15:0] & $past(hit, 2)) == $past(hit, 2))
    else $error("flag lost");
  a_unmapped_zero: assert property (rd && !rdf && !rdm |=> hrdata == 32'h0) else $error("unmapped");
endmodule // phyifm_props
`default_nettype wire

// ==== verif/phyifm_top_bench.sv ====
// Testbench: mask, event, clear-on-read and interrupt scenarios
`timescale 1ns/10ps
`default_nettype none
bind phyifm_top phyifm_props i_props (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .evt(evt), .irq(irq));
module phyifm_top_bench;
  logic                    core_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, irq, rdy, resp;
  logic [1:0]              htrans = 2'h0;
  logic [31:0]             haddr = 32'h0, hwdata = 32'h0, hrdata, q, d, m;
  phyifm_pkg::phyifm_evt_t evt = '0;
  int                      mismatches = 0, n_compared = 0, cyc = 0;
  phyifm_top i_dut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy),
    .hresp(resp), .evt(evt), .irq(irq));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp || resp !== 1'b0) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] exp_mask(input logic [31:0] v);
    return {16'h0000, v[15:0] & phyifm_pkg::VALID_BITS};
  endfunction
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= phyifm_pkg::HTRANS_NONSEQ;
    do @(posedge core_clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (rdy !== 1'b1);
    q = hrdata;
  endtask
  // Link stays a level; energy pulses so that each call gives a fresh rising edge
  task automatic fire(input int b);
    @(posedge core_clk);
    case (b)
      9: evt.link_status <= 1'b1;
      4: evt.link_status <= 1'b0;
      8: evt.wake_on_network <= 1'b1;
      7: evt.energy_present_indication <= 1'b1;
      6: evt.autoneg_done <= 1'b1;
      5: evt.remote_fault <= 1'b1;
      3: evt.partner_ack <= 1'b1;
      2: evt.parallel_detect_fault <= 1'b1;
      default: evt.page_received <= 1'b1;
    endcase
    @(posedge core_clk);
    evt <= {evt.link_status, 7'h00};
    repeat (2) @(posedge core_clk);
  endtask
  initial begin
    void'($urandom(91));
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    bus(1'b0, phyifm_pkg::ADDR_SOURCE_FLAGS, 32'h0);
    check(q, 32'h0);
    m = 32'h0;
    for (int r = 0; r < 5; r++) begin
      d = (r == 0) ? 32'hffffffff : (r == 1) ? 32'h0 : $urandom;
      bus(1'b0, phyifm_pkg::ADDR_ENABLE_MASK, 32'h0);
      check(q, m);
      bus(1'b1, phyifm_pkg::ADDR_ENABLE_MASK, d);
      m = exp_mask(d);
      bus(1'b0, phyifm_pkg::ADDR_ENABLE_MASK, 32'h0);
      check(q, m);
      for (int b = 9; b > 0; b--) begin
        fire(b);
        check({31'h0, irq}, {31'h0, d[b]});
        bus(1'b0, phyifm_pkg::ADDR_SOURCE_FLAGS, 32'h0);
        check(q, {16'h0, d[15:0] & (16'h1 << b)});
        bus(1'b0, phyifm_pkg::ADDR_SOURCE_FLAGS, 32'h0);
        check(q, 32'h0);
        check({31'h0, irq}, 32'h0);
      end
    end
    bus(1'b1, 32'h00000070, 32'hffffffff);
    bus(1'b0, 32'h00000070, 32'h0);
    check(q, 32'h0);
    // Write-one clear of one flag, then an event riding the read edge
    bus(1'b1, phyifm_pkg::ADDR_ENABLE_MASK, 32'hffffffff);
    fire(1);
    fire(3);
    bus(1'b1, phyifm_pkg::ADDR_SOURCE_FLAGS, 32'h00000002);
    bus(1'b0, phyifm_pkg::ADDR_SOURCE_FLAGS, 32'h0);
    check(q, 32'h00000008);
    @(posedge core_clk);
    evt.page_received <= 1'b1;
    bus(1'b0, phyifm_pkg::ADDR_SOURCE_FLAGS, 32'h0);
    evt.page_received <= 1'b0;
    check(q, 32'h00000002);
    bus(1'b0, phyifm_pkg::ADDR_SOURCE_FLAGS, 32'h0);
    check(q, 32'h00000002);
    fire(6);
    check({31'h0, irq}, 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    check({31'h0, irq}, 32'h0);
    bus(1'b0, phyifm_pkg::ADDR_SOURCE_FLAGS, 32'h0);
    check(q, 32'h0);
    bus(1'b0, phyifm_pkg::ADDR_ENABLE_MASK, 32'h0);
    check(q, 32'h0);
    close_out();
  end
endmodule // phyifm_top_bench
`default_nettype wire
